/* rtl/dim_ctrl_device.sv */
// device end: pwm gating, monitor pin select, analog dimming reference, limp home and calibration
//
// What this block does
// RL1 - either pwm source high enables gate drivers
// RL2 - direct dim pin high enables, low disables
// RL3 - register pwm bit enables or disables drivers
// RL4 - boost, monitor bit low: mirror pwm
// RL5 - buck feedback; boost bit selects feedback/mirror
// RL6 - host stops channels via idle or enable
// RL7 - reference select high uses external set pin
// RL8 - reference select low uses 8-bit code
// RL9 - zero code stops; nonzero restarts soft start
// RL10 - limp-home pin high enters limp home
// RL11 - limp home needs dim pin and enable
// RL12 - limp home takes setting from set pin
// RL13 - limp-home entry resets registers to defaults
// RL14 - set below 100mV stops, above 200mV restarts
// RL15 - host zeroes current before calibrating
// RL16 - host sets calibration enable, then start
// RL17 - routine runs about 200us, then done flag
// RL18 - enable high: routine result applied, read back
// RL19 - enable low: written value used, start ignored
// RL20 - code 24 means about ten percent dimming
// RL21 - host recalibrates while dim pin long low
// RL22 - accepted start clears the done flag
`timescale 1ns/10ps
module dim_ctrl_device import dim_cal_pkg::*; #(
  parameter int CAL_CYCLES = CAL_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // link to the host
  dim_link_if.dev link,
  // analog status from the power stage
  input wire logic [NUM_CH-1:0] boost_mode_i,
  input wire logic [NUM_CH-1:0] set_below_i,
  input wire logic [NUM_CH-1:0] set_above_i,
  input wire logic [NUM_CH-1:0] short_gnd_i,
  input wire logic [NUM_CH-1:0][CODE_W-1:0] cal_measure_i,
  // controls to the power stage
  output logic [NUM_CH-1:0] gate_en_o,
  output logic [NUM_CH-1:0] soft_start_o,
  output logic [NUM_CH-1:0] ref_ext_o,
  output logic [NUM_CH-1:0][CODE_W-1:0] adim_o,
  output logic [NUM_CH-1:0][CODE_W-1:0] cal_value_o,
  output logic [NUM_CH-1:0] cal_busy_o,
  // current monitor pin function and limp state
  output logic [NUM_CH-1:0] mon_fb_o,
  output logic [NUM_CH-1:0] mon_mirror_o,
  output logic [NUM_CH-1:0] mon_short_o,
  output logic limp_o
);

  localparam logic [CNT_W-1:0] CAL_LOAD = CNT_W'(CAL_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  // register address decode, shared by every write path and the device control read
  function automatic logic hit(input logic [ADDR_W-1:0] a, input int ch, input logic [2:0] idx);
    hit = (a == {ch[0], idx});
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // limp home and device-wide control

  logic limp_q;
  logic idle;
  logic [NUM_CH-1:0][DATA_W-1:0] rd_val;
  wire limp_rise = link.limp_pin & ~limp_q; // RL10
  wire reg_clr = ~rst_n_i | limp_rise; // RL13
  wire wr_dev = link.reg_wr & hit(link.reg_addr, 0, IDX_DEVCTL);
  wire rd_ch = link.reg_addr[ADDR_W-1];
  wire [DATA_W-1:0] dev_val = {7'h00, idle};
  wire [DATA_W-1:0] next_rdata = hit(link.reg_addr, 0, IDX_DEVCTL) ? dev_val : rd_val[rd_ch];

  // limp state follows the pin; the rising edge clears the register file once
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      limp_q <= 1'b0;
    else
      limp_q <= link.limp_pin; // RL10
  end

  // idle stops both channels together outside limp home, as the host's safe stop
  always_ff @(posedge clk_i)
  begin
    if (reg_clr)
      idle <= 1'b0;
    else if (wr_dev)
      idle <= link.reg_wdata[DEV_IDLE_BIT]; // RL6
  end

  // read data stand from the cycle after the read until the next read
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      link.reg_rdata <= DATA_ZERO;
    else if (link.reg_rd)
      link.reg_rdata <= next_rdata;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      limp_o <= 1'b0;
    else
      limp_o <= limp_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel logic

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    logic pwm_bit;
    logic cal_en;
    logic mon_sel;
    logic ref_sel;
    logic done;
    logic busy;
    logic set_stop;
    logic [CODE_W-1:0] adim;
    logic [CODE_W-1:0] calval;
    logic [CODE_W-1:0] cal_res;
    logic [CNT_W-1:0] cnt;

    // write decode
    wire wr_loop = link.reg_wr & hit(link.reg_addr, c, IDX_LOOP);
    wire wr_mon = link.reg_wr & hit(link.reg_addr, c, IDX_MON);
    wire wr_cal = link.reg_wr & hit(link.reg_addr, c, IDX_CALCTL);
    wire wr_adim = link.reg_wr & hit(link.reg_addr, c, IDX_ADIM);
    wire wr_cval = link.reg_wr & hit(link.reg_addr, c, IDX_CALVAL);
    // a start is only taken with the routine enabled; otherwise it is dropped silently
    wire start_ok = wr_cal & link.reg_wdata[CAL_START_BIT] & cal_en & ~busy & ~limp_q; // RL19
    wire cal_end = busy & (cnt == CNT_ZERO);
    // reference source and stop conditions
    wire ext_ref = limp_q | ref_sel; // RL7 RL12
    wire zero_stop = ~limp_q & (adim == ADIM_OFF); // RL8 RL9
    wire restart_code = wr_adim & ~limp_q & (adim == ADIM_OFF) & (link.reg_wdata != ADIM_OFF); // RL9
    wire restart_set = set_stop & set_above_i[c]; // RL14
    // either pwm source high wins; limp home listens to the pin alone
    wire pwm_act = limp_q ? link.dim_pin[c] : (link.dim_pin[c] | pwm_bit); // RL1 RL2 RL3 RL11
    wire enable_ok = limp_q ? link.enable_pin : (link.enable_pin & ~idle); // RL6 RL11
    // drivers stay off during the routine so the output current stays at zero
    wire next_gate = pwm_act & enable_ok & ~zero_stop & ~set_stop & ~busy;
    wire [CODE_W-1:0] applied = cal_en ? cal_res : calval; // RL18 RL19
    wire mirror_sel = boost_mode_i[c] & ~mon_sel; // RL5
    wire [DATA_W-1:0] loop_val = {6'h00, cal_en, pwm_bit};
    wire [DATA_W-1:0] cal_val = {4'h0, busy, done, 1'b0, ref_sel};
    wire [DATA_W-1:0] mon_val = {7'h00, mon_sel};

    assign rd_val[c] = (link.reg_addr[2:0] == IDX_LOOP) ? loop_val :
                       (link.reg_addr[2:0] == IDX_MON) ? mon_val :
                       (link.reg_addr[2:0] == IDX_CALCTL) ? cal_val :
                       (link.reg_addr[2:0] == IDX_ADIM) ? adim :
                       (link.reg_addr[2:0] == IDX_CALVAL) ? applied : DATA_ZERO; // RL18

    // software-written control bits, back to defaults on reset or limp entry
    always_ff @(posedge clk_i)
    begin
      if (reg_clr)
      begin
        pwm_bit <= 1'b0;
        cal_en <= 1'b0;
        mon_sel <= 1'b0;
        ref_sel <= 1'b0;
      end
      else
      begin
        if (wr_loop)
        begin
          pwm_bit <= link.reg_wdata[LOOP_PWM_BIT]; // RL3
          cal_en <= link.reg_wdata[LOOP_CALEN_BIT];
        end
        if (wr_mon)
          mon_sel <= link.reg_wdata[MON_SEL_BIT]; // RL4 RL5
        if (wr_cal)
          ref_sel <= link.reg_wdata[CAL_REF_BIT]; // RL7
      end
    end

    // dimming code and host calibration value
    always_ff @(posedge clk_i)
    begin
      if (reg_clr)
      begin
        adim <= ADIM_RESET;
        calval <= CALVAL_RESET;
      end
      else
      begin
        if (wr_adim)
          adim <= link.reg_wdata; // RL8 RL20
        if (wr_cval)
          calval <= link.reg_wdata; // RL19
      end
    end

    // calibration routine timer; the end of the routine sets done
    always_ff @(posedge clk_i)
    begin
      if (reg_clr)
      begin
        busy <= 1'b0;
        cnt <= CNT_ZERO;
      end
      else if (start_ok)
      begin
        busy <= 1'b1;
        cnt <= CAL_LOAD; // RL17
      end
      else if (busy)
      begin
        busy <= ~cal_end;
        cnt <= cnt - 1'b1;
      end
    end

    // done flag: set by the routine end, cleared when a new start is taken
    always_ff @(posedge clk_i)
    begin
      if (reg_clr)
        done <= 1'b0;
      else if (cal_end)
        done <= 1'b1; // RL17
      else if (start_ok)
        done <= 1'b0; // RL22
    end

    // routine result, kept across later disabled periods for reuse
    always_ff @(posedge clk_i)
    begin
      if (!rst_n_i)
        cal_res <= CALVAL_RESET;
      else if (cal_end)
        cal_res <= cal_measure_i[c]; // RL18
    end

    // set-pin low-level stop, released with soft start above the upper level
    always_ff @(posedge clk_i)
    begin
      if (!rst_n_i)
        set_stop <= 1'b0;
      else if (ext_ref & set_below_i[c])
        set_stop <= 1'b1; // RL14
      else if (set_above_i[c] | ~ext_ref)
        set_stop <= 1'b0; // RL14
    end

    // registered outputs
    always_ff @(posedge clk_i)
    begin
      if (!rst_n_i)
      begin
        gate_en_o[c] <= 1'b0;
        soft_start_o[c] <= 1'b0;
        ref_ext_o[c] <= 1'b0;
        adim_o[c] <= ADIM_RESET;
        cal_value_o[c] <= CALVAL_RESET;
        cal_busy_o[c] <= 1'b0;
      end
      else
      begin
        gate_en_o[c] <= next_gate; // RL1
        soft_start_o[c] <= restart_code | restart_set; // RL9 RL14
        ref_ext_o[c] <= ext_ref; // RL12
        adim_o[c] <= adim;
        cal_value_o[c] <= applied; // RL18 RL19
        cal_busy_o[c] <= busy;
      end
    end

    // monitor pin: feedback in buck or when selected, else mirror plus short flag
    always_ff @(posedge clk_i)
    begin
      if (!rst_n_i)
      begin
        mon_fb_o[c] <= 1'b1;
        mon_mirror_o[c] <= 1'b0;
        mon_short_o[c] <= 1'b0;
      end
      else
      begin
        mon_fb_o[c] <= ~mirror_sel; // RL5
        mon_mirror_o[c] <= mirror_sel & next_gate; // RL4
        mon_short_o[c] <= mirror_sel & short_gnd_i[c]; // RL5
      end
    end
  end

endmodule // dim_ctrl_device

/* rtl/dim_cal_pkg.sv */
// constants, register map and state codes shared by both ends of the dimming link
package dim_cal_pkg;
  localparam int NUM_CH = 2;
  localparam int CODE_W = 8;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int HADDR_W = 5;
  localparam int CNT_W = 16;
  // device register index (low three address bits); address bit 3 picks the channel
  localparam logic [2:0] IDX_LOOP = 3'h0;
  localparam logic [2:0] IDX_MON = 3'h1;
  localparam logic [2:0] IDX_CALCTL = 3'h2;
  localparam logic [2:0] IDX_ADIM = 3'h3;
  localparam logic [2:0] IDX_CALVAL = 3'h4;
  localparam logic [2:0] IDX_DEVCTL = 3'h5;
  // bit positions
  localparam int LOOP_PWM_BIT = 0;
  localparam int LOOP_CALEN_BIT = 1;
  localparam int MON_SEL_BIT = 0;
  localparam int CAL_REF_BIT = 0;
  localparam int CAL_START_BIT = 1;
  localparam int CAL_DONE_BIT = 2;
  localparam int CAL_BUSY_BIT = 3;
  localparam int DEV_IDLE_BIT = 0;
  // reset values and special codes
  localparam logic [CODE_W-1:0] ADIM_RESET = 8'hFF;
  localparam logic [CODE_W-1:0] ADIM_OFF = 8'h00;
  localparam logic [CODE_W-1:0] ADIM_TEN_PCT = 8'h18;
  localparam logic [CODE_W-1:0] CALVAL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  // calibration routine time
  localparam int CAL_TIME_US = 200;
  localparam int CLK_MHZ = 40;
  localparam int CAL_CYCLES_DEF = CAL_TIME_US * CLK_MHZ;
  // host-local registers (address bit 4 set)
  localparam logic [HADDR_W-1:0] H_PINS = 5'h10;
  localparam logic [HADDR_W-1:0] H_CALCMD = 5'h11;
  localparam logic [HADDR_W-1:0] H_STATUS = 5'h12;
  localparam logic [HADDR_W-1:0] H_LAST = 5'h13;
  localparam int PIN_EN_BIT = 2;
  localparam int PIN_LIMP_BIT = 3;
  localparam logic [DATA_W-1:0] PINS_RESET = 8'h00;
  // host calibration sequencer, Gray coded from HS_IDLE to HS_DONE; the HS_CHECK to HS_POLL retry flips two bits
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_DIM = 3'b001,
    HS_ENCAL = 3'b011,
    HS_START = 3'b010,
    HS_POLL = 3'b110,
    HS_WAIT = 3'b111,
    HS_CHECK = 3'b101,
    HS_DONE = 3'b100
  } host_state_t;
endpackage

/* rtl/dim_link_if.sv */
// pins and register port between the host controller and the led dimming device
`timescale 1ns/10ps
interface dim_link_if import dim_cal_pkg::*; ();
  logic [NUM_CH-1:0] dim_pin;
  logic enable_pin;
  logic limp_pin;
  logic reg_wr;
  logic reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  modport dev (
    input dim_pin, enable_pin, limp_pin, reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata
  );
  modport host (
    output dim_pin, enable_pin, limp_pin, reg_wr, reg_rd, reg_addr, reg_wdata,
    input reg_rdata
  );
endinterface

/* rtl/dim_ctrl_host.sv */
// host end: drives the dimming pins, forwards register traffic and runs the calibration sequence
`timescale 1ns/10ps
module dim_ctrl_host import dim_cal_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // software command port
  input wire logic [HADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // load switch
  output logic load_off_o,
  // link to the device
  dim_link_if.host link
);

  host_state_t state;
  host_state_t next_state;
  logic [DATA_W-1:0] pins;
  logic [DATA_W-1:0] last;
  logic [NUM_CH-1:0][DATA_W-1:0] loop_sh;
  logic [NUM_CH-1:0][DATA_W-1:0] cal_sh;
  logic [NUM_CH-1:0] dim_hold;
  logic cal_ch;
  logic cal_ok;
  logic rd_pend;

  // decode of the command port; device traffic is refused while sequencing
  wire local_sel = addr_i[HADDR_W-1];
  wire busy = (state != HS_IDLE);
  wire fwd_wr = wr_i & ~local_sel & ~busy;
  wire fwd_rd = rd_i & ~local_sel & ~busy;
  wire cal_go = wr_i & (addr_i == H_CALCMD) & ~busy;
  wire [ADDR_W-1:0] ch_base = {cal_ch, 3'h0};
  wire [DATA_W-1:0] status = {6'h00, cal_ok, busy};
  wire [DATA_W-1:0] next_rdata = (addr_i == H_PINS) ? pins :
                                 (addr_i == H_STATUS) ? status :
                                 (addr_i == H_LAST) ? last : DATA_ZERO;

  ////////////////////////////////////////////////////////////////////////////
  // calibration sequencer

  always_comb
  begin
    next_state = state;
    unique case (state)
      HS_IDLE: if (cal_go) next_state = HS_DIM;
      HS_DIM: next_state = HS_ENCAL;
      HS_ENCAL: next_state = HS_START;
      HS_START: next_state = HS_POLL;
      HS_POLL: next_state = HS_WAIT;
      HS_WAIT: next_state = HS_CHECK;
      HS_CHECK: next_state = link.reg_rdata[CAL_DONE_BIT] ? HS_DONE : HS_POLL;
      HS_DONE: next_state = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      state <= HS_IDLE;
    else
      state <= next_state;
  end

  // channel under calibration and result flag
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cal_ch <= 1'b0;
      cal_ok <= 1'b0;
    end
    else if (cal_go)
    begin
      cal_ch <= wdata_i[0];
      cal_ok <= 1'b0;
    end
    else if (state == HS_DONE)
      cal_ok <= 1'b1;
  end

  // link register traffic: sequencer steps first, software forwarding otherwise
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      link.reg_addr <= 4'h0;
      link.reg_wdata <= DATA_ZERO;
    end
    else
    begin
      link.reg_wr <= fwd_wr | (state == HS_DIM) | (state == HS_ENCAL) | cal_go;
      link.reg_rd <= fwd_rd | (state == HS_POLL);
      if (cal_go)
      begin
        link.reg_addr <= {wdata_i[0], IDX_ADIM};
        link.reg_wdata <= ADIM_TEN_PCT; // RL20
      end
      else if (state == HS_DIM)
      begin
        link.reg_addr <= ch_base | ADDR_W'(IDX_LOOP);
        link.reg_wdata <= loop_sh[cal_ch] | DATA_W'(1 << LOOP_CALEN_BIT); // RL16
      end
      else if (state == HS_ENCAL)
      begin
        link.reg_addr <= ch_base | ADDR_W'(IDX_CALCTL);
        link.reg_wdata <= cal_sh[cal_ch] | DATA_W'(1 << CAL_START_BIT); // RL16
      end
      else if (state == HS_POLL)
        link.reg_addr <= ch_base | ADDR_W'(IDX_CALCTL); // RL17
      else if (fwd_wr | fwd_rd)
      begin
        link.reg_addr <= addr_i[ADDR_W-1:0];
        link.reg_wdata <= wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shadows of device bits the sequencer must preserve on its own writes

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_sh
    wire wr_loop = fwd_wr & (addr_i[ADDR_W-1:0] == {1'(c), IDX_LOOP});
    wire wr_cal = fwd_wr & (addr_i[ADDR_W-1:0] == {1'(c), IDX_CALCTL});
    always_ff @(posedge clk_i)
    begin
      if (!rst_n_i)
      begin
        loop_sh[c] <= DATA_ZERO;
        cal_sh[c] <= DATA_ZERO;
      end
      else
      begin
        if (wr_loop)
          loop_sh[c] <= wdata_i;
        if (wr_cal)
          cal_sh[c] <= wdata_i & DATA_W'(1 << CAL_REF_BIT);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins, load switch and software reads

  // stopping uses the enable pin or idle, never a long-held low dim pin
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      pins <= PINS_RESET;
    else if (wr_i & (addr_i == H_PINS))
      pins <= wdata_i; // RL6
  end

  // dim pin forced low and load opened together for the whole routine
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      dim_hold <= 2'b00;
      load_off_o <= 1'b0;
    end
    else if (cal_go)
    begin
      dim_hold <= wdata_i[0] ? 2'b10 : 2'b01; // RL15 RL21
      load_off_o <= 1'b1; // RL15
    end
    else if (state == HS_DONE)
    begin
      dim_hold <= 2'b00;
      load_off_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      link.dim_pin <= 2'b00;
      link.enable_pin <= 1'b0;
      link.limp_pin <= 1'b0;
    end
    else
    begin
      link.dim_pin <= pins[NUM_CH-1:0] & ~dim_hold; // RL15
      link.enable_pin <= pins[PIN_EN_BIT]; // RL6
      link.limp_pin <= pins[PIN_LIMP_BIT];
    end
  end

  // forwarded read data land in the last-read register two cycles on
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_pend <= 1'b0;
      last <= DATA_ZERO;
      rdata_o <= DATA_ZERO;
    end
    else
    begin
      rd_pend <= link.reg_rd & ~busy;
      if (rd_pend)
        last <= link.reg_rdata;
      if (rd_i)
        rdata_o <= next_rdata;
    end
  end

endmodule // dim_ctrl_host

/* verification/dim_link_assertions.sv */
// concurrent checks on the dimming link and the device outputs beside it
`timescale 1ns/10ps
module dim_link_assertions import dim_cal_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // link signals
  input wire logic [NUM_CH-1:0] dim_pin,
  input wire logic enable_pin,
  input wire logic limp_pin,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // device side
  input wire logic [NUM_CH-1:0] boost_mode_i,
  input wire logic [NUM_CH-1:0] gate_en_o,
  input wire logic [NUM_CH-1:0] cal_busy_o,
  input wire logic [NUM_CH-1:0] mon_fb_o,
  input wire logic [NUM_CH-1:0] mon_mirror_o,
  input wire logic limp_o
);
  // generous upper bound on the shortened calibration run
  localparam int CAL_MAX = 40;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  // gate enable is computed one cycle after its inputs
  a_gate_needs_enable: assert property (gate_en_o[0] |-> $past(enable_pin))
    else $error("gate on without enable pin");
  // limp_o and gate_en_o are both launched from the same limp state sample
  a_limp_gate_pins: assert property (gate_en_o[1] && limp_o |-> $past(dim_pin[1] && enable_pin))
    else $error("limp gate on without dim and enable pins");
  a_limp_entry: assert property ($rose(limp_pin) |-> ##[1:2] limp_o)
    else $error("limp state not entered");
  a_limp_exit: assert property (!limp_pin [*3] |-> !limp_o)
    else $error("limp state without limp pin");
  a_buck_feedback: assert property (!boost_mode_i[0] ##1 !boost_mode_i[0] |-> mon_fb_o[0])
    else $error("buck channel monitor pin not feedback");
  a_mirror_excl_fb: assert property (mon_mirror_o[0] |-> !mon_fb_o[0])
    else $error("mirror and feedback both selected");
  a_cal_busy_time: assert property ($rose(cal_busy_o[0]) |-> cal_busy_o[0] [*8] ##[1:CAL_MAX] !cal_busy_o[0])
    else $error("calibration run length wrong");
  a_gate_off_cal: assert property (cal_busy_o[0] |-> !gate_en_o[0])
    else $error("gate on during calibration");
  a_rdata_stands: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without a read");
endmodule // dim_link_assertions

/* verification/led_dimming_calibration_ctrl_tb.sv */
// self-checking bench: host and device ends joined over the dimming link
`timescale 1ns/10ps
module led_dimming_calibration_ctrl_tb import dim_cal_pkg::*;;
  logic clk_i, rst_n_i, wr_i, rd_i, load_off_o, limp_o, en;
  logic [HADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o, m;
  logic [NUM_CH-1:0] boost_mode_i, set_below_i, set_above_i, short_gnd_i, gate_en_o, soft_start_o;
  logic [NUM_CH-1:0] ref_ext_o, cal_busy_o, mon_fb_o, mon_mirror_o, mon_short_o, dim, pwm;
  logic [NUM_CH-1:0][CODE_W-1:0] cal_measure_i, adim_o, cal_value_o;
  int bad_count, n_checks, seed, i;
  dim_link_if link();
  dim_ctrl_device #(.CAL_CYCLES(20)) dim_ctrl_device_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link),
    .boost_mode_i(boost_mode_i), .set_below_i(set_below_i), .set_above_i(set_above_i),
    .short_gnd_i(short_gnd_i), .cal_measure_i(cal_measure_i), .gate_en_o(gate_en_o),
    .soft_start_o(soft_start_o), .ref_ext_o(ref_ext_o), .adim_o(adim_o), .cal_value_o(cal_value_o),
    .cal_busy_o(cal_busy_o), .mon_fb_o(mon_fb_o), .mon_mirror_o(mon_mirror_o), .mon_short_o(mon_short_o),
    .limp_o(limp_o));
  dim_ctrl_host dim_ctrl_host_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .load_off_o(load_off_o), .link(link));
  dim_link_assertions dim_link_assertions_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .dim_pin(link.dim_pin),
    .enable_pin(link.enable_pin), .limp_pin(link.limp_pin), .reg_rd(link.reg_rd),
    .reg_rdata(link.reg_rdata), .boost_mode_i(boost_mode_i), .gate_en_o(gate_en_o),
    .cal_busy_o(cal_busy_o), .mon_fb_o(mon_fb_o), .mon_mirror_o(mon_mirror_o), .limp_o(limp_o));
  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // gate enable expected outside limp, calibration and idle
  function automatic logic [1:0] exp_gate(input logic [1:0] d, input logic [1:0] p, input logic e);
    return (d | p) & {2{e}};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one software strobe; read data stand just after the second edge
  task automatic sw(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    sw(1'b0, a, 8'h00);
    #1;
    chk(rdata_o, exp);
  endtask
  // device registers are reached by forwarding; the answer lands in the last-read register
  task automatic dev_rd(input logic ch, input logic [2:0] idx, input logic [7:0] exp);
    sw(1'b0, {1'b0, ch, idx}, 8'h00);
    repeat (3) @(posedge clk_i);
    rd_chk(H_LAST, exp);
  endtask
  task automatic dev_wr(input logic ch, input logic [2:0] idx, input logic [7:0] d);
    sw(1'b1, {1'b0, ch, idx}, d);
  endtask
  task automatic pins(input logic l, input logic e, input logic [1:0] d);
    sw(1'b1, H_PINS, {4'h0, l, e, d});
  endtask
  // pin flop plus gate flop, with margin
  task automatic settle();
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {wr_i, rd_i, addr_i, wdata_i, boost_mode_i, set_below_i, set_above_i, short_gnd_i} = '0;
    cal_measure_i = '0;
    bad_count = 0;
    n_checks = 0;
    seed = 69;
    rst_n_i = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle();
    chk(8'(gate_en_o), 8'h00);
    chk(8'(mon_fb_o), 8'h03);
    chk(adim_o[1], ADIM_RESET);
    rd_chk(H_PINS, PINS_RESET);
    dev_rd(1'b0, IDX_CALVAL, CALVAL_RESET);
    dev_rd(1'b1, 3'h7, DATA_ZERO);
    $display("test reset done");
    // random mix of pin and register sources, enable pin included
    for (i = 0; i < 12; i++)
    begin
      {en, pwm, dim} = 5'($random(seed));
      dev_wr(1'b0, IDX_LOOP, {7'h00, pwm[0]});
      dev_wr(1'b1, IDX_LOOP, {7'h00, pwm[1]});
      pins(1'b0, en, dim);
      settle();
      chk(8'(gate_en_o), 8'(exp_gate(dim, pwm, en)));
    end
    $display("test pwm done");
    pins(1'b0, 1'b1, 2'b00);
    dev_wr(1'b0, IDX_LOOP, 8'h01);
    dev_wr(1'b0, IDX_ADIM, ADIM_OFF);
    settle();
    chk(8'(gate_en_o[0]), 8'h00);
    chk(adim_o[0], ADIM_OFF);
    dev_wr(1'b0, IDX_ADIM, ADIM_TEN_PCT);
    i = 0;
    while (soft_start_o[0] !== 1'b1 && i < 10)
    begin
      @(posedge clk_i);
      #1;
      i++;
    end
    chk(8'(i < 10), 8'h01);
    settle();
    chk(8'(gate_en_o[0]), 8'h01);
    dev_wr(1'b0, IDX_CALCTL, 8'h01);
    settle();
    chk(8'(ref_ext_o[0]), 8'h01);
    set_below_i <= 2'b01;
    settle();
    chk(8'(gate_en_o[0]), 8'h00);
    set_below_i <= 2'b00;
    set_above_i <= 2'b01;
    settle();
    chk(8'(gate_en_o[0]), 8'h01);
    set_above_i <= 2'b00;
    dev_wr(1'b0, IDX_CALCTL, 8'h00);
    $display("test analog done");
    // monitor pin function in boost and buck
    boost_mode_i <= 2'b11;
    short_gnd_i <= 2'b11;
    settle();
    chk(8'(mon_fb_o), 8'h00);
    chk(8'(mon_mirror_o), 8'({pwm[1], 1'b1}));
    chk(8'(mon_short_o), 8'h03);
    dev_wr(1'b0, IDX_MON, 8'h01);
    settle();
    chk(8'(mon_fb_o), 8'h01);
    chk(8'(mon_short_o), 8'h02);
    boost_mode_i <= 2'b01;
    settle();
    chk(8'(mon_fb_o), 8'h03);
    boost_mode_i <= 2'b11;
    pins(1'b1, 1'b1, 2'b10);
    settle();
    chk(8'(limp_o), 8'h01);
    chk(8'(mon_fb_o), 8'h00);
    chk(8'(ref_ext_o), 8'h03);
    chk(8'(gate_en_o), 8'h02);
    pins(1'b1, 1'b0, 2'b11);
    settle();
    chk(8'(gate_en_o), 8'h00);
    pins(1'b0, 1'b1, 2'b00);
    boost_mode_i <= 2'b00;
    short_gnd_i <= 2'b00;
    settle();
    chk(8'(limp_o), 8'h00);
    $display("test limp done");
    // host calibration sequence on channel 0
    m = 8'($random(seed));
    cal_measure_i[0] <= m;
    sw(1'b1, H_CALCMD, 8'h00);
    settle();
    chk(8'(load_off_o), 8'h01);
    chk(adim_o[0], ADIM_TEN_PCT);
    chk(8'(cal_busy_o[0]), 8'h01);
    i = 0;
    do
    begin
      sw(1'b0, H_STATUS, 8'h00);
      #1;
      i++;
    end
    while (rdata_o[1] !== 1'b1 && i < 100);
    if (i >= 100)
    begin
      bad_count++;
      give_verdict();
    end
    chk(8'(load_off_o), 8'h00);
    chk(cal_value_o[0], m);
    dev_rd(1'b0, IDX_CALVAL, m);
    dev_rd(1'b0, IDX_CALCTL, 8'h04);
    dev_wr(1'b0, IDX_CALCTL, 8'h02);
    dev_rd(1'b0, IDX_CALCTL, 8'h08);
    repeat (30) @(posedge clk_i);
    dev_wr(1'b0, IDX_LOOP, 8'h00);
    dev_wr(1'b0, IDX_CALVAL, 8'h5a);
    dev_rd(1'b0, IDX_CALVAL, 8'h5a);
    chk(cal_value_o[0], 8'h5a);
    dev_wr(1'b0, IDX_CALCTL, 8'h02);
    settle();
    chk(8'(cal_busy_o[0]), 8'h00);
    $display("test calibration done");
    give_verdict();
  end
endmodule // led_dimming_calibration_ctrl_tb
